// ==== ar_regs.svh ====
`ifndef AR_REGS_SVH
`define AR_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// global register byte offsets
`define AR_CFG_OFS             16'h0000
`define AR_CMD_OFS             16'h0004
`define AR_STATUS_OFS          16'h0008

// per group block at 0x0100 + 0x20 * group
`define AR_GRP_PAGE            8'h01
`define AR_G_CTRL_OFS          5'h00
`define AR_G_LOCKOUT_OFS       5'h04
`define AR_G_CREC_OFS          5'h08
`define AR_G_SHOTEN_OFS        5'h0c
`define AR_G_DISCR_OFS         5'h10

// shot timer table at 0x2000 + 4 * {group, request, shot, field}
`define AR_MEM_PAGE            3'h1

////////////////////////////////////////////////////////////////////////////////
// field positions
`define AR_CFG_ONOFF_BIT       0
`define AR_CFG_GRP_LSB         8
`define AR_CMD_UNLOCK_BIT      0
`define AR_CTRL_EN_BIT         0
`define AR_CTRL_CLOSE_RST_BIT  1
`define AR_CTRL_GEN_REC_BIT    2
`define AR_CTRL_OBJ_LSB        4

////////////////////////////////////////////////////////////////////////////////
// reset values, sizes and timing
`define AR_CTRL_RST            7'h00
`define AR_LOCKOUT_RST         22'h000000
`define AR_CLOSE_RECLAIM_MS    10000
`define AR_NUM_GROUPS          4
`define AR_TIME_W              22
`define AR_CLK_PERIOD_NS       10
`define AR_TICK_US             500

`endif

// ==== ar_pkg.sv ====
package ar_pkg;

  // sequencer states
  typedef enum logic [3:0] {
    ST_READY,
    ST_START,
    ST_OPEN,
    ST_DEAD,
    ST_CLOSE,
    ST_ACTION,
    ST_RECLAIM,
    ST_ACT_LOCK,
    ST_LOCKOUT,
    ST_GEN_RECLAIM,
    ST_TRIP_LOCK,
    ST_LOCKED
  } ar_state_t;

  // per shot timer field selector in the table address
  typedef enum logic [1:0] {
    FLD_START,
    FLD_DEAD,
    FLD_ACTION,
    FLD_RECLAIM
  } shot_field_t;

endpackage

// ==== shot_setting_mem.sv ====
`timescale 1ns/1ps

module shot_setting_mem #(
  parameter int DW = 22,
  parameter int AW = 10
) (
  // clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_srst,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata,
  output logic               o_busy
);

  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] clr_q;
  logic          busy_q;

  // after reset every word is swept to zero so all shot timers default to zero
  wire          we    = busy_q | i_we;
  wire [AW-1:0] waddr = busy_q ? clr_q : i_waddr;
  wire [DW-1:0] wdata = busy_q ? '0 : i_wdata;

  // clear sweep counter
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      clr_q  <= '0;
      busy_q <= 1'b1;
    end
    else if (busy_q)
    begin
      clr_q  <= clr_q + 1'b1;
      busy_q <= (clr_q != '1);
    end
  end

  // storage, no reset on the array itself
  always_ff @(posedge i_core_clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // registered read
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_rdata <= '0;
    else
      o_rdata <= mem[i_raddr];
  end

  assign o_busy = busy_q;

endmodule

// ==== auto_reclose_sequencer.sv ====
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "ar_regs.svh"

// How it works
// - drive only the selected one of five breakers
// - per group enable, off by default
// - always read settings of the active group
// - unlock by user command or, when close reset is set, external close of the selected breaker
// - optional general reclaim after shot reclaim
// - post success lockout timer, zero skips the lockout
// - request during lockout: open breaker, lock
// - close reclaim after manual or general close
// - request during close reclaim locks out
// - disabled shots are skipped to next one
// - pickup request must persist for start delay
// - operate request with start delay never starts
// - dead time counts from breaker open
// - keep breaker closed through action time
// - request during action: lock for reclaim
// - zero action time skips action phase
// - request during shot reclaim advances shot
// - timers hold zero to 1800 seconds
// - optional on/off input gates the recloser
module auto_reclose_sequencer #(
  parameter int NUM_GROUPS  = `AR_NUM_GROUPS,
  parameter int TICK_CYCLES = `AR_TICK_US * 1000 / `AR_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [15:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // protection requests, one bit per reclose_request_n
  input  wire logic [4:0]  i_req_start,
  input  wire logic [4:0]  i_req_trip,
  input  wire logic        i_recloser_on_off_input,
  // breaker objects
  input  wire logic [4:0]  i_obj_open,
  input  wire logic [4:0]  i_obj_closed,
  input  wire logic [4:0]  i_ext_close_cmd,
  output logic [4:0]       o_obj_open_cmd,
  output logic [4:0]       o_obj_close_cmd,
  // status
  output logic             o_locked,
  output logic             o_running
);

  localparam int GW = $clog2(NUM_GROUPS);
  localparam int AW = GW + 8;
  localparam int VW = `AR_TIME_W;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [VW-1:0] CREC_RST = VW'(`AR_CLOSE_RECLAIM_MS * 1000 / `AR_TICK_US);

  if (NUM_GROUPS < 2 || NUM_GROUPS > 8 || (1 << GW) != NUM_GROUPS)
    $error("NUM_GROUPS must be 2, 4 or 8");
  if (TICK_CYCLES < 2)
    $error("TICK_CYCLES must be at least 2");

  // first set bit of v at or above index from, msb is the found flag
  function automatic logic [3:0] first_from(input logic [4:0] v, input logic [2:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 4; i >= 0; i--)
    begin
      if (v[i] && 3'(i) >= from)
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, stage one is read only by stage two
  logic [25:0] sync1_q;
  logic [25:0] sync2_q;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {i_recloser_on_off_input, i_ext_close_cmd, i_obj_closed,
                  i_obj_open, i_req_trip, i_req_start};
      sync2_q <= sync1_q;
    end
  end

  wire [4:0] req_start = sync2_q[4:0];
  wire [4:0] req_trip  = sync2_q[9:5];
  wire [4:0] obj_open  = sync2_q[14:10];
  wire [4:0] obj_close = sync2_q[19:15];
  wire [4:0] ext_close = sync2_q[24:20];
  wire       onoff     = sync2_q[25];

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, word transfers only
  logic        dp_wr_q;
  logic [15:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic        mem_busy;
  logic [31:0] rd_word;

  wire addr_ph = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2);

  // address phase capture, read data is registered for the data phase
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
      hrdata_q  <= '0;
    end
    else
    begin
      dp_wr_q <= addr_ph & i_hwrite;
      if (addr_ph)
        dp_addr_q <= i_haddr;
      if (addr_ph & ~i_hwrite)
        hrdata_q <= rd_word;
    end
  end

  // write decode
  wire         wr_cfg = dp_wr_q && dp_addr_q == `AR_CFG_OFS;
  wire         wr_cmd = dp_wr_q && dp_addr_q == `AR_CMD_OFS;
  wire         wr_grp = dp_wr_q && dp_addr_q[15:8] == `AR_GRP_PAGE;
  wire [2:0]   wg     = dp_addr_q[7:5];
  wire [4:0]   wo     = dp_addr_q[4:0];
  wire         wr_mem = dp_wr_q && dp_addr_q[15:13] == `AR_MEM_PAGE;
  wire         lock_clr = wr_cmd && i_hwdata[`AR_CMD_UNLOCK_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic          use_onoff_q;
  logic [GW-1:0] grp_q;
  logic [6:0]    gctrl_q [NUM_GROUPS];
  logic [VW-1:0] glock_q [NUM_GROUPS];
  logic [VW-1:0] gcrec_q [NUM_GROUPS];
  logic [24:0]   gen_q   [NUM_GROUPS];
  logic [24:0]   gdis_q  [NUM_GROUPS];

  // global configuration
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      use_onoff_q <= 1'b0;
      grp_q       <= '0;
    end
    else if (wr_cfg)
    begin
      use_onoff_q <= i_hwdata[`AR_CFG_ONOFF_BIT];
      grp_q       <= i_hwdata[`AR_CFG_GRP_LSB +: GW];
    end
  end

  // per group settings, each group keeps its own copy
  always_ff @(posedge i_core_clk)
  begin
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      if (i_srst)
      begin
        gctrl_q[g] <= `AR_CTRL_RST;
        glock_q[g] <= `AR_LOCKOUT_RST;
        gcrec_q[g] <= CREC_RST;
        gen_q[g]   <= '0;
        gdis_q[g]  <= '0;
      end
      else if (wr_grp && wg == 3'(g))
      begin
        if (wo == `AR_G_CTRL_OFS)
          gctrl_q[g] <= i_hwdata[6:0];
        if (wo == `AR_G_LOCKOUT_OFS)
          glock_q[g] <= i_hwdata[VW-1:0];
        if (wo == `AR_G_CREC_OFS)
          gcrec_q[g] <= i_hwdata[VW-1:0];
        if (wo == `AR_G_SHOTEN_OFS)
          gen_q[g] <= i_hwdata[24:0];
        if (wo == `AR_G_DISCR_OFS)
          gdis_q[g] <= i_hwdata[24:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // active group selection, re-evaluated every cycle
  wire [6:0]    actl      = gctrl_q[grp_q];
  wire [VW-1:0] lock_time = glock_q[grp_q];
  wire [VW-1:0] crec_time = gcrec_q[grp_q];
  wire [24:0]   shot_en   = gen_q[grp_q];
  wire          close_rst = actl[`AR_CTRL_CLOSE_RST_BIT];
  wire          gen_rec   = actl[`AR_CTRL_GEN_REC_BIT];
  wire [2:0]    obj_raw   = actl[`AR_CTRL_OBJ_LSB +: 3];
  wire [2:0]    obj_sel   = (obj_raw > 3'h4) ? 3'h0 : obj_raw;
  wire [4:0]    obj_hot   = 5'h01 << obj_sel;
  wire          run_en    = actl[`AR_CTRL_EN_BIT] && (!use_onoff_q || onoff);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer state
  ar_pkg::ar_state_t   state_q;
  ar_pkg::ar_state_t   state_d;
  ar_pkg::shot_field_t fld;
  logic [2:0]    req_q;
  logic [2:0]    req_d;
  logic [2:0]    shot_q;
  logic [2:0]    shot_d;
  logic          pickup_q;
  logic          pickup_d;
  logic [4:0]    req_prev_q;
  logic [4:0]    ext_prev_q;
  logic [TW-1:0] pre_q;
  logic [VW-1:0] el_q;
  logic [AW-1:0] raddr_q;
  logic [VW-1:0] mem_rdata;
  logic [4:0]    open_q;
  logic [4:0]    close_q;
  logic          locked_q;
  logic          running_q;

  // request and breaker events on the selected object
  wire [4:0] req_act  = req_start | req_trip;
  wire [4:0] new_vec  = req_act & ~req_prev_q;
  wire       new_req  = |new_vec;
  wire       brk_open = |(obj_open & obj_hot);
  wire       brk_cls  = |(obj_close & obj_hot);
  wire       ext_rise = |(ext_close & ~ext_prev_q & obj_hot);

  // shot selection for a fresh request and for the running one
  wire [3:0] pick  = first_from(new_vec, 3'h0);
  wire [2:0] pr    = pick[2:0];
  wire [3:0] pshot = first_from(shot_en[pr * 5 +: 5], 3'h0);
  wire [3:0] nshot = first_from(shot_en[req_q * 5 +: 5], 3'(shot_q + 3'h1));

  // timer setting lookup; the table answers one cycle after its address settles
  assign fld = (state_q == ar_pkg::ST_START)  ? ar_pkg::FLD_START :
               (state_q == ar_pkg::ST_DEAD)   ? ar_pkg::FLD_DEAD :
               (state_q == ar_pkg::ST_ACTION) ? ar_pkg::FLD_ACTION : ar_pkg::FLD_RECLAIM;
  wire [AW-1:0] mem_raddr = {grp_q, req_q, shot_q, fld};
  wire          reg_timer = state_q == ar_pkg::ST_LOCKOUT || state_q == ar_pkg::ST_GEN_RECLAIM;
  wire [VW-1:0] tval      = (state_q == ar_pkg::ST_LOCKOUT)     ? lock_time :
                            (state_q == ar_pkg::ST_GEN_RECLAIM) ? crec_time : mem_rdata;
  wire          t_ok      = reg_timer || (mem_raddr == raddr_q && !mem_busy);
  wire          expired   = t_ok && el_q >= tval;
  wire          set_zero  = t_ok && tval == '0;

  // next state
  always_comb
  begin
    state_d  = state_q;
    req_d    = req_q;
    shot_d   = shot_q;
    pickup_d = pickup_q;
    if (!run_en && state_q != ar_pkg::ST_LOCKED)
      state_d = ar_pkg::ST_READY;
    else
    begin
      unique case (state_q)
        ar_pkg::ST_READY:
          if (new_req)
          begin
            req_d    = pr;
            pickup_d = req_start[pr] && !req_trip[pr];
            shot_d   = pshot[2:0];
            state_d  = pshot[3] ? ar_pkg::ST_START : ar_pkg::ST_LOCKED;
          end
          else if (ext_rise)
            state_d = ar_pkg::ST_GEN_RECLAIM;
        ar_pkg::ST_START:
          if (t_ok && !pickup_q)
            state_d = set_zero ? ar_pkg::ST_OPEN : ar_pkg::ST_READY;
          else if (!req_act[req_q])
            state_d = ar_pkg::ST_READY;
          else if (expired)
            state_d = ar_pkg::ST_OPEN;
        ar_pkg::ST_OPEN:
          if (brk_open)
            state_d = ar_pkg::ST_DEAD;
        ar_pkg::ST_DEAD:
          if (expired)
            state_d = ar_pkg::ST_CLOSE;
        ar_pkg::ST_CLOSE:
          if (brk_cls)
            state_d = ar_pkg::ST_ACTION;
        ar_pkg::ST_ACTION:
          if (set_zero)
            state_d = ar_pkg::ST_RECLAIM;
          else if (new_req)
            state_d = ar_pkg::ST_ACT_LOCK;
          else if (expired)
            state_d = ar_pkg::ST_RECLAIM;
        ar_pkg::ST_RECLAIM:
          if (new_req)
          begin
            shot_d  = nshot[3] ? nshot[2:0] : shot_q;
            state_d = nshot[3] ? ar_pkg::ST_START : ar_pkg::ST_LOCKED;
          end
          else if (expired)
            state_d = (lock_time != '0) ? ar_pkg::ST_LOCKOUT :
                      gen_rec ? ar_pkg::ST_GEN_RECLAIM : ar_pkg::ST_READY;
        ar_pkg::ST_ACT_LOCK:
          if (expired)
            state_d = ar_pkg::ST_READY;
        ar_pkg::ST_LOCKOUT:
          if (new_req)
            state_d = ar_pkg::ST_TRIP_LOCK;
          else if (expired)
            state_d = gen_rec ? ar_pkg::ST_GEN_RECLAIM : ar_pkg::ST_READY;
        ar_pkg::ST_GEN_RECLAIM:
          if (new_req)
            state_d = ar_pkg::ST_LOCKED;
          else if (expired)
            state_d = ar_pkg::ST_READY;
        ar_pkg::ST_TRIP_LOCK:
          if (brk_open)
            state_d = ar_pkg::ST_LOCKED;
        ar_pkg::ST_LOCKED:
          if (lock_clr || (close_rst && ext_rise))
            state_d = ar_pkg::ST_READY;
        default:
          state_d = ar_pkg::ST_READY;
      endcase
    end
  end

  // state registers and edge history
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_q    <= ar_pkg::ST_READY;
      req_q      <= '0;
      shot_q     <= '0;
      pickup_q   <= 1'b0;
      req_prev_q <= '0;
      ext_prev_q <= '0;
      raddr_q    <= '0;
    end
    else
    begin
      state_q    <= state_d;
      req_q      <= req_d;
      shot_q     <= shot_d;
      pickup_q   <= pickup_d;
      req_prev_q <= req_act;
      ext_prev_q <= ext_close;
      raddr_q    <= mem_raddr;
    end
  end

  // tick prescaler; a coarse tick keeps every timer to a single 22 bit counter
  wire tick = pre_q == TW'(TICK_CYCLES - 1);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || tick)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  // one elapsed counter serves every phase, restarted on each state change
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || state_d != state_q)
      el_q <= '0;
    else if (tick && el_q != '1)
      el_q <= el_q + 1'b1;
  end

  // breaker commands go only to the selected object
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      open_q    <= '0;
      close_q   <= '0;
      locked_q  <= 1'b0;
      running_q <= 1'b0;
    end
    else
    begin
      open_q    <= (state_d == ar_pkg::ST_OPEN || state_d == ar_pkg::ST_TRIP_LOCK) ?
                   obj_hot : 5'h00;
      close_q   <= (state_d == ar_pkg::ST_CLOSE) ? obj_hot : 5'h00;
      locked_q  <= state_d == ar_pkg::ST_LOCKED;
      running_q <= state_d != ar_pkg::ST_READY && state_d != ar_pkg::ST_LOCKED;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shot timer table
  shot_setting_mem #(
    .DW (VW),
    .AW (AW)
  ) u_shot_mem (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_we       (wr_mem && !mem_busy),
    .i_waddr    (dp_addr_q[AW+1:2]),
    .i_wdata    (i_hwdata[VW-1:0]),
    .i_raddr    (mem_raddr),
    .o_rdata    (mem_rdata),
    .o_busy     (mem_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read mux from the address phase
  wire [2:0]    rgi    = i_haddr[7:5];
  wire [GW-1:0] rg     = rgi[GW-1:0];
  wire [4:0]    ro     = i_haddr[4:0];
  wire          rg_ok  = i_haddr[15:8] == `AR_GRP_PAGE && {1'b0, rgi} < 4'(NUM_GROUPS);
  wire [31:0]   cfg_w  = {21'h0, 3'(grp_q), 7'h0, use_onoff_q};
  wire [31:0]   stat_w = {12'h0, mem_busy, !run_en, running_q, locked_q, 1'b0, shot_q,
                          1'b0, req_q, 4'h0, state_q};
  wire [31:0]   grp_w  = (ro == `AR_G_CTRL_OFS)    ? {25'h0, gctrl_q[rg]} :
                         (ro == `AR_G_LOCKOUT_OFS) ? {10'h0, glock_q[rg]} :
                         (ro == `AR_G_CREC_OFS)    ? {10'h0, gcrec_q[rg]} :
                         (ro == `AR_G_SHOTEN_OFS)  ? {7'h0, gen_q[rg]} :
                         (ro == `AR_G_DISCR_OFS)   ? {7'h0, gdis_q[rg]} : 32'h0;
  assign rd_word = (i_haddr == `AR_CFG_OFS)    ? cfg_w :
                   (i_haddr == `AR_STATUS_OFS) ? stat_w :
                   rg_ok ? grp_w : 32'h0;

  // outputs
  assign o_hreadyout     = 1'b1;
  assign o_hresp         = 1'b0;
  assign o_hrdata        = hrdata_q;
  assign o_obj_open_cmd  = open_q;
  assign o_obj_close_cmd = close_q;
  assign o_locked        = locked_q;
  assign o_running       = running_q;

endmodule

// ==== auto_reclose_sequencer_assertions.sv ====
`timescale 1ns/1ps

module auto_reclose_sequencer_assertions (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_srst,
  // requests and breaker position
  input  wire logic [4:0] i_req_start,
  input  wire logic [4:0] i_req_trip,
  input  wire logic [4:0] i_obj_open,
  input  wire logic [4:0] i_obj_closed,
  // commands and status
  input  wire logic [4:0] o_obj_open_cmd,
  input  wire logic [4:0] o_obj_close_cmd,
  input  wire logic       o_locked,
  input  wire logic       o_running
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  // any request pin active, pickup or operate
  wire logic req_any = |(i_req_start | i_req_trip);

  ////////////////////////////////////////////////////////////////////////////
  // commands reach one object only
  AST_OPEN_ONE: assert property ($onehot0(o_obj_open_cmd))
    else $error("open command on several objects");
  AST_CLOSE_ONE: assert property ($onehot0(o_obj_close_cmd))
    else $error("close command on several objects");
  AST_NO_FIGHT: assert property ((o_obj_open_cmd & o_obj_close_cmd) == 5'h00)
    else $error("open and close command together");
  // a reclose only ever closes a breaker that stands open
  AST_CLOSE_OPEN: assert property ($rose(|o_obj_close_cmd)
    |-> (o_obj_close_cmd & i_obj_open) != 5'h00)
    else $error("close command to a breaker that is not open");
  AST_CLOSE_HOLD: assert property ($fell(|o_obj_close_cmd) |-> |i_obj_closed)
    else $error("close command dropped before breaker closed");
  AST_OPEN_HOLD: assert property ($fell(|o_obj_open_cmd) |-> |i_obj_open)
    else $error("open command dropped before breaker opened");
  // an open command always answers a request seen a few cycles earlier
  AST_OPEN_CAUSE: assert property ($rose(|o_obj_open_cmd) |-> $past(req_any, 3))
    else $error("open command without a request");
  AST_LOCK_IDLE: assert property (o_locked |-> !o_running)
    else $error("locked while running");
  AST_LOCK_NOCLOSE: assert property ($rose(o_locked) |-> o_obj_close_cmd == 5'h00)
    else $error("close command on entering locked state");
endmodule

bind auto_reclose_sequencer auto_reclose_sequencer_assertions i_chk (
  .i_core_clk      (i_core_clk),
  .i_srst          (i_srst),
  .i_req_start     (i_req_start),
  .i_req_trip      (i_req_trip),
  .i_obj_open      (i_obj_open),
  .i_obj_closed    (i_obj_closed),
  .o_obj_open_cmd  (o_obj_open_cmd),
  .o_obj_close_cmd (o_obj_close_cmd),
  .o_locked        (o_locked),
  .o_running       (o_running)
);

// ==== breaker_model.sv ====
`timescale 1ns/1ps

module breaker_model #(
  parameter int DLY = 3
) (
  // clock
  input  wire logic       i_core_clk,
  // commands
  input  wire logic [4:0] i_open_cmd,
  input  wire logic [4:0] i_close_cmd,
  input  wire logic [4:0] i_ext_close,
  // position
  output logic      [4:0] o_open,
  output logic      [4:0] o_closed
);
  logic [4:0] pos_q = 5'h1f;
  int         cnt_q [5];

  // travel takes DLY+1 cycles, so a command pulse that drops early never moves it
  always @(posedge i_core_clk)
  begin
    for (int k = 0; k < 5; k++)
    begin
      if (i_ext_close[k])
        pos_q[k] <= 1'b1;
      else if ((i_open_cmd[k] && pos_q[k]) || (i_close_cmd[k] && !pos_q[k]))
      begin
        cnt_q[k] <= cnt_q[k] + 1;
        if (cnt_q[k] == DLY)
        begin
          pos_q[k] <= ~pos_q[k];
          cnt_q[k] <= 0;
        end
      end
      else
        cnt_q[k] <= 0;
    end
  end

  // position contacts are complementary
  assign o_closed = pos_q;
  assign o_open   = ~pos_q;
endmodule

// ==== test_auto_reclose_sequencer.sv ====
`timescale 1ns/1ps

module test_auto_reclose_sequencer;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [4:0]  rqs = 5'h00;
  logic [4:0]  rqt = 5'h00;
  logic        onoff = 1'b0;
  logic [4:0]  ext = 5'h00;
  wire logic   hrdy;
  wire logic   hresp;
  wire logic [31:0] hrdata;
  wire logic [4:0]  ocmd;
  wire logic [4:0]  ccmd;
  wire logic [4:0]  obj_open;
  wire logic [4:0]  obj_closed;
  wire logic   locked;
  wire logic   running;
  logic [31:0] d;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t0;

  // short tick keeps the timers in simulation reach
  auto_reclose_sequencer #(.TICK_CYCLES(4)) i_auto_reclose_sequencer (
    .i_core_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_req_start(rqs), .i_req_trip(rqt), .i_recloser_on_off_input(onoff),
    .i_obj_open(obj_open), .i_obj_closed(obj_closed), .i_ext_close_cmd(ext),
    .o_obj_open_cmd(ocmd), .o_obj_close_cmd(ccmd), .o_locked(locked),
    .o_running(running));
  breaker_model i_breaker_model (
    .i_core_clk(clk), .i_open_cmd(ocmd), .i_close_cmd(ccmd), .i_ext_close(ext),
    .o_open(obj_open), .o_closed(obj_closed));

  // clock, cycle count and watchdog
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic rng(input string n, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi)
    begin
      $display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, g);
      err_count++;
    end
  endtask
  // one single word transfer; the slave may stretch either phase
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(a, 1'b1, v, x);
  endtask
  task automatic cst(input string n, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(16'h0008, 1'b0, 32'h0, x);
    chk(n, e, x & m);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [15:0] ta(input int r, input int s, input int f);
    return 16'(32'h2000 + (r * 32 + s * 4 + f) * 4);
  endfunction
  // one shot of request 1 on object 3: dead time 20 ticks
  task automatic run(input int s);
    rqt[0] <= 1'b1;
    while (ocmd === 5'h00) @(posedge clk);
    chk("open", 32'h4, ocmd);
    rqt[0] <= 1'b0;
    cst("shot", 32'h7000, s << 12);
    while (obj_open[2] !== 1'b1) @(posedge clk);
    t0 = cyc;
    while (ccmd === 5'h00) @(posedge clk);
    rng("dead", 80, 94, cyc - t0);
    while (ccmd !== 5'h00) @(posedge clk);
    cst("state", 32'hf, ar_pkg::ST_RECLAIM);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    wt(10);
    srst <= 1'b0;
    wt(1100);
    bus(16'h0000, 1'b0, 32'h0, d); chk("cfg", 32'h0, d);
    bus(16'h0100, 1'b0, 32'h0, d); chk("ctrl", 32'h0, d);
    bus(16'h0104, 1'b0, 32'h0, d); chk("lockout", 32'h0, d);
    bus(16'h0108, 1'b0, 32'h0, d); chk("crec", 32'h4e20, d);
    bus(16'h0040, 1'b0, 32'h0, d); chk("unmapped", 32'h0, d);
    // shots 2 and 3 of request 1, shot 1 of request 2
    wr(16'h010c, 32'h26);
    for (int s = 1; s < 3; s++)
    begin
      wr(ta(0, s, 1), 32'd20);
      wr(ta(0, s, 3), 32'd30);
    end
    wr(ta(1, 0, 0), 32'd5);
    wr(ta(1, 0, 2), 32'd10);
    wr(ta(1, 0, 3), 32'd15);
    // disabled group ignores requests
    wr(16'h0100, 32'h20);
    rqt[0] <= 1'b1;
    wt(20);
    chk("open", 32'h0, ocmd);
    cst("inhibit", 32'h40000, 32'h40000);
    rqt[0] <= 1'b0;
    wr(16'h0100, 32'h21);
    run(1);
    run(2);
    rqt[0] <= 1'b1;
    while (locked !== 1'b1) @(posedge clk);
    chk("open", 32'h0, ocmd);
    rqt[0] <= 1'b0;
    wr(16'h0004, 32'h1);
    wt(4);
    chk("locked", 32'h0, locked);
    // post success lock-out, then a request trips and locks
    wr(16'h0104, 32'd40);
    run(1);
    wt(130);
    cst("state", 32'hf, ar_pkg::ST_LOCKOUT);
    rqt[0] <= 1'b1;
    while (ocmd !== 5'h04) @(posedge clk);
    rqt[0] <= 1'b0;
    while (locked !== 1'b1) @(posedge clk);
    cst("state", 32'hf, ar_pkg::ST_LOCKED);
    // close command from outside unlocks when so set
    wr(16'h0108, 32'd50);
    wr(16'h0100, 32'h23);
    ext[2] <= 1'b1;
    wt(2);
    ext[2] <= 1'b0;
    wt(10);
    chk("locked", 32'h0, locked);
    wr(16'h0104, 32'h0);
    wr(16'h0100, 32'h21);
    wt(250);
    // operate origin with a start delay never starts
    rqt[1] <= 1'b1;
    wt(40);
    chk("open", 32'h0, ocmd);
    cst("state", 32'hf, ar_pkg::ST_READY);
    rqt[1] <= 1'b0;
    wt(4);
    rqs[1] <= 1'b1;
    t0 = cyc;
    while (ocmd === 5'h00) @(posedge clk);
    rng("start", 20, 34, cyc - t0);
    rqs[1] <= 1'b0;
    while (ccmd === 5'h00) @(posedge clk);
    while (ccmd !== 5'h00) @(posedge clk);
    cst("state", 32'hf, ar_pkg::ST_ACTION);
    rqt[1] <= 1'b1;
    wt(8);
    cst("state", 32'hf, ar_pkg::ST_ACT_LOCK);
    rqt[1] <= 1'b0;
    wt(80);
    // manual close starts close reclaim; a request then locks
    ext[2] <= 1'b1;
    wt(2);
    ext[2] <= 1'b0;
    wt(6);
    cst("state", 32'hf, ar_pkg::ST_GEN_RECLAIM);
    rqt[0] <= 1'b1;
    wt(10);
    chk("locked", 32'h1, locked);
    rqt[0] <= 1'b0;
    wr(16'h0004, 32'h1);
    // group 2 is disabled; the on/off input gates when used
    wr(16'h0000, 32'h100);
    cst("inhibit", 32'h40000, 32'h40000);
    wr(16'h0000, 32'h1);
    cst("inhibit", 32'h40000, 32'h40000);
    onoff <= 1'b1;
    wt(4);
    cst("inhibit", 32'h40000, 32'h0);
    // general reclaim
    wr(16'h0100, 32'h25);
    run(1);
    wt(130);
    cst("state", 32'hf, ar_pkg::ST_GEN_RECLAIM);
    conclude();
  end
endmodule
